/* File: design/tpic_pkg.sv */
// package: register map, field positions, reset values and types of the irq control block
package tpic_pkg;

  // ****************************************************************
  // register map (byte addresses on the bus, low address byte only)
  // ****************************************************************
  localparam logic [7:0] TPIC_IDX_ICTL = 8'h0B; // register index of interrupt_control
  localparam logic [7:0] TPIC_ADDR_ICTL = 8'(TPIC_IDX_ICTL * 8'h04);
  localparam logic [7:0] TPIC_IDX_PEN = 8'h0C; // register index of peripheral_enable_reg
  localparam logic [7:0] TPIC_ADDR_PEN = 8'(TPIC_IDX_PEN * 8'h04);
  localparam logic [7:0] TPIC_ADDR_STAT = 8'h40; // sticky event status, read clears
  localparam logic [7:0] TPIC_ADDR_MASK = 8'h44; // event mask

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int TPIC_GIE_BIT = 7;
  localparam int TPIC_PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int TPIC_TIMER_OVERFLOW_IRQ_ENABLE_BIT = 5;
  localparam int TPIC_TIMER_OVERFLOW_FLAG_BIT = 2;
  localparam int TPIC_ST_TOV_BIT = 0; // timer overflow event
  localparam int TPIC_ST_REQ_BIT = 1; // core request rising event
  localparam int TPIC_NPER = 5; // capture, serial, port change, capture timer ovf, button

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] TPIC_ICTL_RST = 8'h00;
  localparam logic [7:0] TPIC_PEN_RST = 8'h00;
  localparam logic [1:0] TPIC_STAT_RST = 2'h0;
  localparam logic [1:0] TPIC_MASK_RST = 2'h0;

  // ****************************************************************
  // types
  // ****************************************************************
  // data phase bookkeeping of the bus front end
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
  } tpic_dph_type;

  // whole state of the register block
  typedef struct packed {
    logic [7:0] ictl;
    logic [7:0] pen;
    logic [1:0] stat;
    logic [1:0] mask;
    logic req;
    logic irq;
    logic ready;
    logic [31:0] rdata;
  } tpic_state_type;

  // word address match on the low address byte
  function automatic logic tpic_hit(input logic [7:0] a, input logic [7:0] base);
    return a[7:2] == base[7:2];
  endfunction

endpackage

/* File: design/tpic_ahb_front.sv */
// module: ahb-lite address/data phase front end of the irq control block
`timescale 1ns/100ps
module tpic_ahb_front
  import tpic_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite address phase
  input wire logic hsel,
  input wire logic [7:0] haddr_lo,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  // register side strobes
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic rd_en,
  output logic [7:0] rd_addr
);

  tpic_dph_type s_r;
  tpic_dph_type s_nxt;
  logic take;

  // ****************************************************************
  // address phase acceptance
  // ****************************************************************
  // a transfer is taken when selected, ready and nonseq or seq
  assign take = hsel & hready & htrans[1];
  // reads are served at the address phase edge so data stands in the data phase
  assign rd_en = take & ~hwrite;
  assign rd_addr = haddr_lo;
  // writes land one edge later, when hwdata is on the bus
  assign wr_en = s_r.wr;
  assign wr_addr = s_r.addr;

  // next data phase state
  always_comb begin
    s_nxt = s_r;
    if (hready) begin
      s_nxt.wr = take & hwrite;
      s_nxt.addr = haddr_lo;
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

/* File: design/tpic_top.sv */
// module: interrupt control register block with timer and peripheral request gating
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/100ps
module tpic_top
  import tpic_pkg::*;
#(
  parameter int NPER = TPIC_NPER
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // event sources on the same clock
  input wire logic tmr_overflow,
  input wire logic [NPER-1:0] periph_flag,
  // requests
  output logic core_irq_req,
  output logic irq
);

  localparam logic [7:0] PEN_MASK = 8'((1 << NPER) - 1);

  tpic_state_type s_r;
  tpic_state_type s_nxt;
  logic wr_en;
  logic [7:0] wr_addr;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [NPER-1:0] pen_use;
  logic tmr_src;
  logic per_src;
  logic [1:0] ev;
  logic rd_stat;
  logic unused_ok;

  // ****************************************************************
  // bus front end
  // ****************************************************************
  tpic_ahb_front u_front (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr_lo(haddr[7:0]),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .rd_en(rd_en),
    .rd_addr(rd_addr)
  );

  // only whole words are used; size and upper address bits are not decoded
  assign unused_ok = ^{hsize, haddr[31:8]};

  // ****************************************************************
  // register update, request forming, read data
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.ready = 1'b1; // zero wait states
    // software writes; control reserved bits stored as written, peripheral enable bits above NPER dropped
    if (wr_en && tpic_hit(wr_addr, TPIC_ADDR_ICTL)) begin
      s_nxt.ictl = hwdata[7:0];
    end
    if (wr_en && tpic_hit(wr_addr, TPIC_ADDR_PEN)) begin
      s_nxt.pen = hwdata[7:0] & PEN_MASK;
    end
    if (wr_en && tpic_hit(wr_addr, TPIC_ADDR_MASK)) begin
      s_nxt.mask = hwdata[1:0];
    end
    // overflow sets the flag after the write, so the set wins
    if (tmr_overflow) begin
      s_nxt.ictl[TPIC_TIMER_OVERFLOW_FLAG_BIT] = 1'b1;
    end
    // request gating on the updated control values
    pen_use = s_nxt.pen[NPER-1:0];
    tmr_src = s_nxt.ictl[TPIC_TIMER_OVERFLOW_FLAG_BIT] & s_nxt.ictl[TPIC_TIMER_OVERFLOW_IRQ_ENABLE_BIT];
    per_src = s_nxt.ictl[TPIC_PERIPHERAL_IRQ_ENABLE_BIT] & (|(periph_flag & pen_use));
    s_nxt.req = s_nxt.ictl[TPIC_GIE_BIT] & (tmr_src | per_src);
    // sticky events; a read clears but a same-cycle event survives
    ev = 2'h0;
    ev[TPIC_ST_TOV_BIT] = tmr_overflow;
    ev[TPIC_ST_REQ_BIT] = s_nxt.req & ~s_r.req;
    rd_stat = rd_en & tpic_hit(rd_addr, TPIC_ADDR_STAT);
    s_nxt.stat = rd_stat ? ev : (s_r.stat | ev);
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
    // read data registered at the address phase edge, unmapped reads zero
    if (rd_en) begin
      s_nxt.rdata = 32'h0000_0000;
      if (tpic_hit(rd_addr, TPIC_ADDR_ICTL)) begin
        s_nxt.rdata[7:0] = s_nxt.ictl;
      end
      if (tpic_hit(rd_addr, TPIC_ADDR_PEN)) begin
        s_nxt.rdata[7:0] = s_nxt.pen;
      end
      if (rd_stat) begin
        s_nxt.rdata[1:0] = s_r.stat;
      end
      if (tpic_hit(rd_addr, TPIC_ADDR_MASK)) begin
        s_nxt.rdata[1:0] = s_nxt.mask;
      end
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r.ictl <= TPIC_ICTL_RST;
      s_r.pen <= TPIC_PEN_RST;
      s_r.stat <= TPIC_STAT_RST;
      s_r.mask <= TPIC_MASK_RST;
      s_r.req <= 1'b0;
      s_r.irq <= 1'b0;
      s_r.ready <= 1'b1;
      s_r.rdata <= 32'h0000_0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register, hresp tied low
  assign hreadyout = s_r.ready;
  assign hresp = 1'b0;
  assign hrdata = s_r.rdata;
  assign core_irq_req = s_r.req;
  assign irq = s_r.irq;

  // ****************************************************************
  // assertions
  // ****************************************************************
  // every check runs on hclk and is off while reset is low, except a_reset_ctl_zero which runs in reset
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_timer_overflow_flag_set_on_ovf: assert property (tmr_overflow |=> s_r.ictl[TPIC_TIMER_OVERFLOW_FLAG_BIT])
    else $error("timer flag not set after overflow");
  a_timer_overflow_flag_no_autoclr: assert property (
    s_r.ictl[TPIC_TIMER_OVERFLOW_FLAG_BIT] && !(wr_en && tpic_hit(wr_addr, TPIC_ADDR_ICTL))
    |=> s_r.ictl[TPIC_TIMER_OVERFLOW_FLAG_BIT])
    else $error("timer flag cleared without a write");
  a_tmr_req_pass: assert property (
    s_r.ictl[TPIC_GIE_BIT] && s_r.ictl[TPIC_TIMER_OVERFLOW_IRQ_ENABLE_BIT] && s_r.ictl[TPIC_TIMER_OVERFLOW_FLAG_BIT]
    |-> core_irq_req)
    else $error("enabled timer flag gives no request");
  a_per_blocked: assert property (
    !s_r.ictl[TPIC_PERIPHERAL_IRQ_ENABLE_BIT] && !(s_r.ictl[TPIC_TIMER_OVERFLOW_IRQ_ENABLE_BIT] && s_r.ictl[TPIC_TIMER_OVERFLOW_FLAG_BIT])
    |-> !core_irq_req)
    else $error("request with peripherals blocked");
  a_per_pass: assert property (
    s_r.ictl[TPIC_GIE_BIT] && s_r.ictl[TPIC_PERIPHERAL_IRQ_ENABLE_BIT]
    && |($past(periph_flag) & s_r.pen[NPER-1:0]) |-> core_irq_req)
    else $error("enabled peripheral flag gives no request");
  a_gie_gates_all: assert property (!s_r.ictl[TPIC_GIE_BIT] |-> !core_irq_req)
    else $error("request while global enable clear");
  a_req_formula: assert property (##1 core_irq_req == (s_r.ictl[TPIC_GIE_BIT]
    && ((s_r.ictl[TPIC_TIMER_OVERFLOW_FLAG_BIT] && s_r.ictl[TPIC_TIMER_OVERFLOW_IRQ_ENABLE_BIT])
    || (s_r.ictl[TPIC_PERIPHERAL_IRQ_ENABLE_BIT] && |($past(periph_flag) & s_r.pen[NPER-1:0])))))
    else $error("core request does not match enables and flags");
  a_reset_ctl_zero: assert property (@(posedge hclk) disable iff (1'b0)
    !hresetn |-> s_r.ictl[7:1] == 7'h00)
    else $error("control bits not zero in reset");
  a_pen_width: assert property ((s_r.pen & ~PEN_MASK) == 8'h00)
    else $error("unimplemented peripheral enable bit set");
  a_ictl_read_map: assert property (
    rd_en && tpic_hit(rd_addr, TPIC_ADDR_ICTL) |=> hrdata[7:5] == s_r.ictl[7:5]
    && hrdata[31:8] == 24'h00_0000)
    else $error("control read does not show enable fields");
  a_irq_level: assert property (irq == |(s_r.stat & s_r.mask))
    else $error("interrupt output does not follow masked status");
  // a control write lands as written unless an overflow sets the flag at that edge
  a_ictl_write_lands: assert property (
    wr_en && tpic_hit(wr_addr, TPIC_ADDR_ICTL) && !tmr_overflow
    |=> s_r.ictl == $past(hwdata[7:0]))
    else $error("control write did not land");
  // every overflow leaves its sticky status bit set
  a_stat_ovf_set: assert property (tmr_overflow |=> s_r.stat[TPIC_ST_TOV_BIT])
    else $error("overflow status bit not set");
  // status bits drop only on a status read
  a_stat_sticky: assert property (
    !rd_stat |=> (s_r.stat & $past(s_r.stat)) == $past(s_r.stat))
    else $error("status bit dropped without a read");
  // read data stands until the next read address phase
  a_rdata_stands: assert property (!rd_en |=> $stable(hrdata))
    else $error("read data changed without a read");
  // zero wait states once out of reset
  a_ready_high: assert property (hreadyout)
    else $error("bus ready low");
  // a rising core request is recorded in the status register
  a_req_rise_stat: assert property ($rose(core_irq_req) |-> s_r.stat[TPIC_ST_REQ_BIT])
    else $error("request rise not recorded in status");

  c_timer_req: cover property (tmr_overflow ##1 core_irq_req);
  c_periph_req: cover property (s_r.ictl[TPIC_PERIPHERAL_IRQ_ENABLE_BIT] && core_irq_req);
  c_stat_clear: cover property (rd_en && tpic_hit(rd_addr, TPIC_ADDR_STAT) && |s_r.stat);
  c_irq_out: cover property ($rose(irq));
  // software clearing the timer flag
  c_timer_overflow_flag_clear: cover property ($fell(s_r.ictl[TPIC_TIMER_OVERFLOW_FLAG_BIT]));

endmodule

/* File: sim/tpic_evsrc.sv */
// partner model: timer overflow source and peripheral flag sources on the core clock
`timescale 1ns/100ps
module tpic_evsrc
  import tpic_pkg::*;
(
  // clock
  input wire logic hclk,
  // event outputs toward the block
  output logic tmr_overflow,
  output logic [TPIC_NPER-1:0] periph_flag
);
  // one-cycle overflow pulse per timer wrap, launched just after an edge
  task automatic pulse();
    @(posedge hclk);
    tmr_overflow <= 1'b1;
    @(posedge hclk);
    tmr_overflow <= 1'b0;
  endtask

  // peripheral flags are plain levels held until changed
  task automatic flags(input logic [TPIC_NPER-1:0] v);
    @(posedge hclk);
    periph_flag <= v;
  endtask

  // quiet sources at time zero
  initial begin
    tmr_overflow = 1'b0;
    periph_flag = '0;
  end
endmodule

/* File: sim/timer_and_peripheral_irq_control_test.sv */
// testbench: register access, request gating and status interrupt of the irq control block
`timescale 1ns/100ps
module timer_and_peripheral_irq_control_test
  import tpic_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, tmr_overflow;
  logic core_irq_req, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [TPIC_NPER-1:0] periph_flag;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  localparam logic [7:0] UNMAPPED = 8'h50;

  // ****************************************************************
  // instances
  // ****************************************************************
  tpic_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tmr_overflow(tmr_overflow),
    .periph_flag(periph_flag), .core_irq_req(core_irq_req), .irq(irq));
  tpic_evsrc ev (.hclk(hclk), .tmr_overflow(tmr_overflow), .periph_flag(periph_flag));
  assign hready = hreadyout; // single slave

  // ****************************************************************
  // clock, timeout and helpers
  // ****************************************************************
  // 25 MHz clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // cut a hang short
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one ahb-lite single word transfer; read data taken at the data phase edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h00000000;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(a, 1'b1, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(a, 1'b0, 32'h00000000, r);
  endtask

  // let registered request outputs follow their cause
  task automatic settle();
    repeat (2) @(posedge hclk);
    #1;
  endtask

  task automatic req_is(input logic e);
    settle();
    chk("core_irq_req", {31'h0, core_irq_req}, {31'h0, e});
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(TPIC_ADDR_ICTL, v); chk("ictl", v, 32'h00000000);
    rd(TPIC_ADDR_PEN, v); chk("pen", v, 32'h00000000);
    rd(TPIC_ADDR_MASK, v); chk("mask", v, 32'h00000000);
    rd(TPIC_ADDR_STAT, v); chk("stat", v, 32'h00000000);
    chk("hreadyout", {31'h0, hreadyout}, 32'h00000001);
    $display("test reset done");
    // overflow with every enable clear still raises the flag, no request
    ev.pulse();
    repeat (4) @(posedge hclk);
    rd(TPIC_ADDR_ICTL, v); chk("ictl", v, 32'h00000004);
    req_is(1'b0);
    wr(TPIC_ADDR_ICTL, 32'h00000024); req_is(1'b0);
    wr(TPIC_ADDR_ICTL, 32'h000000A4); req_is(1'b1);
    wr(TPIC_ADDR_ICTL, 32'h00000084); req_is(1'b0);
    wr(TPIC_ADDR_ICTL, 32'h00000080); // flag cleared by software
    wr(TPIC_ADDR_ICTL, 32'h000000A0); req_is(1'b0);
    rd(TPIC_ADDR_ICTL, v); chk("ictl", v, 32'h000000A0);
    $display("test timer done");
    // peripheral enables gated by the peripheral and global enables
    wr(TPIC_ADDR_PEN, 32'h000000FF);
    rd(TPIC_ADDR_PEN, v); chk("pen", v, 32'h0000001F);
    wr(TPIC_ADDR_ICTL, 32'h00000080);
    for (int i = 0; i < TPIC_NPER; i++) begin
      ev.flags(5'(1 << i)); req_is(1'b0);
    end
    wr(TPIC_ADDR_ICTL, 32'h000000C0);
    for (int i = 0; i < TPIC_NPER; i++) begin
      ev.flags(5'(1 << i)); req_is(1'b1);
    end
    wr(TPIC_ADDR_PEN, 32'h0000001E);
    ev.flags(5'h01); req_is(1'b0);
    ev.flags(5'h02); req_is(1'b1);
    wr(TPIC_ADDR_ICTL, 32'h00000040); req_is(1'b0);
    ev.flags(5'h00);
    $display("test peripheral done");
    // status events, mask and read-clear of the level interrupt
    rd(TPIC_ADDR_STAT, v);
    wr(TPIC_ADDR_MASK, 32'h00000003);
    rd(TPIC_ADDR_MASK, v); chk("mask", v, 32'h00000003);
    wr(TPIC_ADDR_ICTL, 32'h000000A0);
    ev.pulse(); settle();
    chk("irq", {31'h0, irq}, 32'h00000001);
    rd(TPIC_ADDR_STAT, v); chk("stat", v, 32'h00000003);
    settle(); chk("irq", {31'h0, irq}, 32'h00000000);
    rd(TPIC_ADDR_STAT, v); chk("stat", v, 32'h00000000);
    wr(TPIC_ADDR_MASK, 32'h00000000);
    wr(TPIC_ADDR_ICTL, 32'h000000A0);
    ev.pulse(); settle();
    chk("irq", {31'h0, irq}, 32'h00000000);
    rd(UNMAPPED, v); chk("unmapped", v, 32'h00000000);
    chk("hresp", {31'h0, hresp}, 32'h00000000);
    $display("test interrupt done");
    finish_test();
  end
endmodule
